// *** src/atc_top.sv ***
// converter trigger select, sequencing and boundary compare with apb regs
//
// Register access over APB and the register offsets were left to the implementer.
`include "atc_defines.svh"
`default_nettype none
module atc_top
  import atc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pwm match flags and converter data
  input  wire logic        pwm_period_match_flag,
  input  wire logic [2:0]  pwm_duty_match_flag,
  input  wire logic [11:0] conv_result_value,
  // analog front end control
  output logic             converter_power_enable,
  output logic             ext_path_en,
  output logic      [3:0]  external_channel_field,
  output logic             amp_path_en,
  output logic             gnd_path_en,
  output logic             sample_en,
  // interrupt requests
  output logic             conv_irq,
  output logic             cmp_irq
);
  logic [7:0]  ctrl0_q;
  logic [7:0]  insel_q;
  logic [7:0]  trig_q;
  logic [7:0]  delay_q;
  logic [11:0] result_q;
  logic [11:0] low_q;
  logic [11:0] high_q;
  logic [1:0]  irq_en_q;
  logic [1:0]  irq_st_q;
  logic        busy_q;
  logic        start_prev_q;
  logic        pwm_prev_q;
  logic [4:0]  tick_cnt_q;
  atc_conv_state_e state_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        ext_path_q;
  logic [3:0]  ext_ch_q;
  logic        amp_path_q;
  logic        gnd_path_q;
  logic        sample_q;
  logic        conv_irq_q;
  logic        cmp_irq_q;

  logic        wr_en;
  logic        rd_hit;
  logic [7:0]  rd_byte;
  logic [7:0]  wbyte;
  logic        align;
  logic        power_en;
  atc_src_e    src;
  logic        duty_flag;
  logic        sel_flag;
  logic        pwm_edge;
  logic        delay_fire;
  logic        start_fall;
  logic        start_req;
  logic        start_ok;
  logic        tick;
  logic        conv_done;
  logic        lo_hit;
  logic        hi_hit;
  logic        cmp_hit;

  assign wbyte    = pwdata[7:0];
  assign align    = ctrl0_q[`ATC_B_ALIGN];
  assign power_en = ctrl0_q[`ATC_B_POWER];
  assign wr_en    = psel && penable && pwrite && pready_q;

  // pack a 12-bit value into the high or low byte of its pair
  function automatic logic [7:0] pack(input logic [11:0] v,
                                      input logic hi, input logic al);
    if (!al) begin
      pack = hi ? v[11:4] : {v[3:0], 4'h0};
    end else begin
      pack = hi ? {4'h0, v[11:8]} : v[7:0];
    end
  endfunction

  // merge a written byte into a 12-bit value under the current format
  function automatic logic [11:0] merge(input logic [11:0] v,
                                        input logic [7:0] b,
                                        input logic hi, input logic al);
    logic [11:0] r;
    r = v;
    if (!al) begin
      if (hi) r[11:4] = b;
      else    r[3:0]  = b[7:4];
    end else begin
      if (hi) r[11:8] = b[3:0];
      else    r[7:0]  = b;
    end
    merge = r;
  endfunction

  // source decode
  always_comb begin
    case (insel_q[7:5])
      `ATC_SRC_AMP_CODE:  src = ATC_SRC_AMP;
      `ATC_SRC_GND0_CODE: src = ATC_SRC_GND;
      `ATC_SRC_GND1_CODE: src = ATC_SRC_GND;
      default:            src = ATC_SRC_EXT;
    endcase
  end

  // trigger path
  always_comb begin
    case (trig_q[1:0])
      2'b00:   duty_flag = pwm_duty_match_flag[0];
      2'b01:   duty_flag = pwm_duty_match_flag[1];
      default: duty_flag = pwm_duty_match_flag[2];
    endcase
  end

  assign sel_flag   = trig_q[`ATC_B_PWM_SEL] ? duty_flag
                                             : pwm_period_match_flag;
  assign pwm_edge   = sel_flag && !pwm_prev_q;
  assign start_fall = start_prev_q && !ctrl0_q[`ATC_B_START];

  always_comb begin
    if (!trig_q[`ATC_B_TRIG_SEL]) begin
      start_req = start_fall;
    end else if (trig_q[`ATC_B_DELAY_EN]) begin
      start_req = delay_fire;
    end else begin
      start_req = pwm_edge;
    end
  end

  // a trigger while busy or powered down is dropped, not queued
  assign start_ok = start_req && power_en && state_q == ATC_CV_IDLE;

  atc_delay u_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .trig    (pwm_edge && trig_q[`ATC_B_TRIG_SEL]
              && trig_q[`ATC_B_DELAY_EN]),
    .count   (delay_q),
    .fire    (delay_fire)
  );

  atc_clkdiv u_clkdiv (
    .pclk     (pclk),
    .presetn  (presetn),
    .restart  (state_q == ATC_CV_IDLE),
    .div_code (insel_q[2:0]),
    .tick     (tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_prev_q <= 1'b0;
      pwm_prev_q   <= 1'b0;
    end else begin
      start_prev_q <= ctrl0_q[`ATC_B_START];
      pwm_prev_q   <= sel_flag;
    end
  end

  // conversion sequence
  assign conv_done = state_q == ATC_CV_CONVERT && tick &&
    tick_cnt_q == 5'(`ATC_SAMPLE_TICKS + `ATC_CONV_TICKS - 5'd1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ATC_CV_IDLE;
      tick_cnt_q <= 5'h00;
    end else if (!power_en) begin
      state_q    <= ATC_CV_IDLE;
      tick_cnt_q <= 5'h00;
    end else begin
      case (state_q)
        ATC_CV_IDLE: begin
          tick_cnt_q <= 5'h00;
          if (start_ok) state_q <= ATC_CV_SAMPLE;
        end
        ATC_CV_SAMPLE: begin
          if (tick) begin
            tick_cnt_q <= tick_cnt_q + 5'h01;
            if (tick_cnt_q == `ATC_SAMPLE_TICKS - 5'd1) begin
              state_q <= ATC_CV_CONVERT;
            end
          end
        end
        ATC_CV_CONVERT: begin
          if (tick) begin
            tick_cnt_q <= tick_cnt_q + 5'h01;
            if (conv_done) state_q <= ATC_CV_IDLE;
          end
        end
        default: state_q <= ATC_CV_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else if (start_ok) begin
      busy_q <= 1'b1;
    end else if (conv_done || !power_en) begin
      busy_q <= 1'b0;
    end
  end

  // result and boundary compare
  assign lo_hit = conv_result_value <= low_q;
  assign hi_hit = conv_result_value >= high_q;
  always_comb begin
    case (trig_q[4:3])
      2'b00:   cmp_hit = !lo_hit && !hi_hit;
      2'b01:   cmp_hit = lo_hit;
      2'b10:   cmp_hit = hi_hit;
      default: cmp_hit = lo_hit || hi_hit;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= `ATC_RST_VAL12;
    end else if (!power_en) begin
      result_q <= `ATC_RST_VAL12;
    end else if (conv_done) begin
      result_q <= conv_result_value;
    end
  end

  // status flags: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_q <= 2'b00;
    end else begin
      if (wr_en && paddr == `ATC_OFF_IRQ_ST) begin
        irq_st_q <= irq_st_q & ~pwdata[1:0];
      end
      if (conv_done) begin
        irq_st_q[`ATC_B_CONV_IRQ] <= 1'b1;
      end
      if (conv_done && cmp_hit && src == ATC_SRC_AMP) begin
        irq_st_q[`ATC_B_CMP_IRQ] <= 1'b1;
      end
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_q  <= `ATC_RST_BYTE;
      insel_q  <= `ATC_RST_BYTE;
      trig_q   <= `ATC_RST_BYTE;
      delay_q  <= `ATC_RST_BYTE;
      irq_en_q <= 2'b00;
    end else if (wr_en) begin
      case (paddr)
        `ATC_OFF_CTRL0:  ctrl0_q  <= wbyte & 8'hbf;
        `ATC_OFF_INSEL:  insel_q  <= wbyte & 8'he7;
        `ATC_OFF_TRIG:   trig_q   <= wbyte & 8'hfb;
        `ATC_OFF_DELAY:  delay_q  <= wbyte;
        `ATC_OFF_IRQ_EN: irq_en_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // bounds survive power down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_q  <= `ATC_RST_VAL12;
      high_q <= `ATC_RST_VAL12;
    end else if (wr_en) begin
      case (paddr)
        `ATC_OFF_LOW_HI:  low_q  <= merge(low_q, wbyte, 1'b1, align);
        `ATC_OFF_LOW_LO:  low_q  <= merge(low_q, wbyte, 1'b0, align);
        `ATC_OFF_HIGH_HI: high_q <= merge(high_q, wbyte, 1'b1, align);
        `ATC_OFF_HIGH_LO: high_q <= merge(high_q, wbyte, 1'b0, align);
        default: ;
      endcase
    end
  end

  // read mux
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (paddr)
      `ATC_OFF_CTRL0:   rd_byte = {ctrl0_q[7], busy_q, ctrl0_q[5:0]};
      `ATC_OFF_INSEL:   rd_byte = insel_q;
      `ATC_OFF_TRIG:    rd_byte = trig_q;
      `ATC_OFF_DELAY:   rd_byte = delay_q;
      `ATC_OFF_RES_HI:  rd_byte = pack(result_q, 1'b1, align);
      `ATC_OFF_RES_LO:  rd_byte = pack(result_q, 1'b0, align);
      `ATC_OFF_LOW_HI:  rd_byte = pack(low_q, 1'b1, align);
      `ATC_OFF_LOW_LO:  rd_byte = pack(low_q, 1'b0, align);
      `ATC_OFF_HIGH_HI: rd_byte = pack(high_q, 1'b1, align);
      `ATC_OFF_HIGH_LO: rd_byte = pack(high_q, 1'b0, align);
      `ATC_OFF_IRQ_EN:  rd_byte = {6'h00, irq_en_q};
      `ATC_OFF_IRQ_ST:  rd_byte = {6'h00, irq_st_q};
      default:          rd_hit  = 1'b0;
    endcase
  end

  // apb answer registered in setup, so every access has no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && !rd_hit;
      if (psel && !penable && !pwrite) begin
        prdata_q <= {24'h000000, rd_byte};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // analog path controls, registered so no glitch reaches the switches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_path_q <= 1'b0;
      ext_ch_q   <= 4'h0;
      amp_path_q <= 1'b0;
      gnd_path_q <= 1'b0;
      sample_q   <= 1'b0;
    end else begin
      ext_path_q <= src == ATC_SRC_EXT &&
                    ctrl0_q[3:0] < `ATC_CH_FIRST_RSVD;
      ext_ch_q   <= ctrl0_q[3:0];
      amp_path_q <= src == ATC_SRC_AMP;
      gnd_path_q <= src == ATC_SRC_GND;
      sample_q   <= state_q == ATC_CV_SAMPLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_irq_q <= 1'b0;
      cmp_irq_q  <= 1'b0;
    end else begin
      conv_irq_q <= irq_st_q[`ATC_B_CONV_IRQ] && irq_en_q[0];
      cmp_irq_q  <= irq_st_q[`ATC_B_CMP_IRQ] && irq_en_q[1];
    end
  end

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign converter_power_enable = power_en;
  assign ext_path_en            = ext_path_q;
  assign external_channel_field = ext_ch_q;
  assign amp_path_en            = amp_path_q;
  assign gnd_path_en            = gnd_path_q;
  assign sample_en              = sample_q;
  assign conv_irq               = conv_irq_q;
  assign cmp_irq                = cmp_irq_q;

  // helper: cycles spent busy in the current conversion
  logic [11:0] busy_cyc_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cyc_q <= 12'h000;
    end else if (start_ok) begin
      busy_cyc_q <= 12'h000;
    end else if (busy_q) begin
      busy_cyc_q <= busy_cyc_q + 12'h001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start;
    start_ok;
  endsequence
  sequence s_busy_hold;
    busy_q [*2];
  endsequence

  a_busy_on_start: assert property (s_start |=> s_busy_hold)
    else $error("busy flag did not rise on conversion start");
  a_busy_on_done: assert property (conv_done |=> !busy_q)
    else $error("busy flag did not fall at conversion end");
  a_conv_length: assert property (conv_done |->
    busy_cyc_q + 12'h001 == 12'(16'h0010 << insel_q[2:0]))
    else $error("conversion length is not sixteen converter clocks");
  a_result_clear: assert property (
    !power_en |=> result_q == 12'h000)
    else $error("result kept after power down");
  a_ext_isolated: assert property (
    src != ATC_SRC_EXT |=> !ext_path_en)
    else $error("external path joined to internal source");
  a_rsvd_channel: assert property (
    ctrl0_q[3:0] >= `ATC_CH_FIRST_RSVD |=> !ext_path_en)
    else $error("reserved channel connected");
  a_rd_unimpl: assert property (pready && paddr == `ATC_OFF_INSEL
    |-> prdata[4:3] == 2'b00)
    else $error("unimplemented bits read nonzero");
  a_sw_only: assert property (trig_q[`ATC_B_TRIG_SEL] == 1'b0 &&
    !start_fall && state_q == ATC_CV_IDLE |=> !busy_q)
    else $error("conversion started without start pulse");
  a_pwm_direct: assert property (trig_q[7:6] == 2'b10 && pwm_edge &&
    power_en && state_q == ATC_CV_IDLE |=> busy_q)
    else $error("pwm edge did not start conversion");
  a_cmp_raise: assert property (conv_done && cmp_hit &&
    src == ATC_SRC_AMP |=> irq_st_q[1] ##1 cmp_irq == irq_en_q[1])
    else $error("compare interrupt not raised");
  a_cmp_src_only: assert property (conv_done && src != ATC_SRC_AMP &&
    !irq_st_q[1] && !wr_en |=> !irq_st_q[1])
    else $error("compare flag set for non amplifier source");
endmodule
`default_nettype wire

// *** src/atc_defines.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef ATC_DEFINES_SVH
`define ATC_DEFINES_SVH
`define ATC_OFF_CTRL0      8'h00
`define ATC_OFF_INSEL      8'h04
`define ATC_OFF_TRIG       8'h08
`define ATC_OFF_DELAY      8'h0c
`define ATC_OFF_RES_HI     8'h10
`define ATC_OFF_RES_LO     8'h14
`define ATC_OFF_LOW_HI     8'h18
`define ATC_OFF_LOW_LO     8'h1c
`define ATC_OFF_HIGH_HI    8'h20
`define ATC_OFF_HIGH_LO    8'h24
`define ATC_OFF_IRQ_EN     8'h28
`define ATC_OFF_IRQ_ST     8'h2c
`define ATC_B_START        7
`define ATC_B_BUSY         6
`define ATC_B_POWER        5
`define ATC_B_ALIGN        4
`define ATC_B_TRIG_SEL     7
`define ATC_B_DELAY_EN     6
`define ATC_B_PWM_SEL      5
`define ATC_B_CONV_IRQ     0
`define ATC_B_CMP_IRQ      1
`define ATC_RST_BYTE       8'h00
`define ATC_RST_VAL12      12'h000
`define ATC_SRC_AMP_CODE   3'b001
`define ATC_SRC_GND0_CODE  3'b010
`define ATC_SRC_GND1_CODE  3'b011
`define ATC_CH_FIRST_RSVD  4'ha
`define ATC_SAMPLE_TICKS   5'd4
`define ATC_CONV_TICKS     5'd12
`endif

// *** src/atc_pkg.sv ***
// shared types of the converter trigger and compare block
`default_nettype none
package atc_pkg;
  typedef enum logic [1:0] {
    ATC_SRC_EXT,
    ATC_SRC_AMP,
    ATC_SRC_GND
  } atc_src_e;
  typedef enum {
    ATC_CV_IDLE,
    ATC_CV_SAMPLE,
    ATC_CV_CONVERT
  } atc_conv_state_e;
endpackage
`default_nettype wire

// *** src/atc_clkdiv.sv ***
// conversion clock tick generator, power-of-two divider
`default_nettype none
module atc_clkdiv
  import atc_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       restart,
  input  wire logic [2:0] div_code,
  // tick out
  output logic            tick
);
  logic [6:0] cnt_q;
  logic [6:0] mask;

  // code n divides by 2**n, so 000 ticks every cycle
  assign mask = 7'((8'h01 << div_code) - 8'h01);
  assign tick = ((cnt_q & mask) == mask) && !restart;

  // held at zero while idle so every conversion sees full periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 7'h00;
    end else if (restart) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

  a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    tick && div_code != 3'h0 && !restart |=> !tick)
    else $error("conversion tick came too soon");
endmodule
`default_nettype wire

// *** src/atc_delay.sv ***
// start delay counter between pwm event and conversion start
`default_nettype none
module atc_delay
  import atc_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // event and count
  input  wire logic       trig,
  input  wire logic [7:0] count,
  // start request
  output logic            fire
);
  logic       run_q;
  logic [7:0] cnt_q;
  logic [8:0] el_q;
  logic [7:0] want_q;

  // a zero count fires at once; software should not leave it zero
  assign fire = (trig && count == 8'h00) ||
                (run_q && !trig && cnt_q == 8'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (trig) begin
      run_q <= (count != 8'h00);
      cnt_q <= count;
    end else if (run_q) begin
      cnt_q <= cnt_q - 8'h01;
      run_q <= (cnt_q != 8'h01);
    end
  end

  // helper for the check below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      el_q   <= 9'h000;
      want_q <= 8'h00;
    end else if (trig) begin
      el_q   <= 9'h001;
      want_q <= count;
    end else if (el_q != 9'h000 && el_q != 9'h1ff) begin
      el_q <= el_q + 9'h001;
    end
  end

  a_delay_length: assert property (@(posedge pclk) disable iff (!presetn)
    fire && !trig |-> el_q == {1'b0, want_q})
    else $error("delayed start did not match the delay count");
endmodule
`default_nettype wire

// *** tb/atc_top_tb.sv ***
// self-checking bench for the converter trigger and compare block
`include "atc_defines.svh"
`default_nettype none
module atc_top_tb
  import atc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, d;
  logic [31:0] pwdata, prdata, rd;
  logic        pwm_period_match_flag, converter_power_enable, ext_path_en;
  logic [2:0]  pwm_duty_match_flag, div;
  logic [11:0] conv_result_value, v, lo, hi;
  logic        amp_path_en, gnd_path_en, sample_en, conv_irq, cmp_irq;
  logic [3:0]  external_channel_field, ch;
  logic [1:0]  m, en;
  logic [15:0] b;
  logic        al, h, isx;
  int          err_count, n_checks, base, c;

  atc_top u_atc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pwm_period_match_flag,
    .pwm_duty_match_flag, .conv_result_value, .converter_power_enable,
    .ext_path_en, .external_channel_field, .amp_path_en, .gnd_path_en,
    .sample_en, .conv_irq, .cmp_irq);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  function automatic logic [15:0] fmt(input logic [11:0] x, input logic f);
    return f ? {4'h0, x} : {x, 4'h0};
  endfunction

  function automatic logic hit(input logic [11:0] x, l, u,
                               input logic [1:0] md);
    case (md)
      2'b00:   return (x > l) && (x < u);
      2'b01:   return x <= l;
      2'b10:   return x >= u;
      default: return (x <= l) || (x >= u);
    endcase
  endfunction

  // start pulse then poll busy: must be seen set, then cleared
  task automatic conv(input logic f);
    int n;
    logic seen;
    apb(1'b1, `ATC_OFF_CTRL0, {24'h0, 3'b101, f, 4'h0});
    apb(1'b1, `ATC_OFF_CTRL0, {24'h0, 3'b001, f, 4'h0});
    seen = 1'b0;
    n = 0;
    do begin
      apb(1'b0, `ATC_OFF_CTRL0, 32'h0);
      if (rd[6] === 1'b1) seen = 1'b1;
      n++;
    end while ((rd[6] !== 1'b0 || !seen) && n < 1000);
    if (n >= 1000) begin
      err_count++;
      tally_and_finish();
    end
  endtask

  // cycles from pwm flag rise to sampling start, -1 if no start
  task automatic lat(input logic [7:0] tg, input logic [7:0] dl,
                     input int f, output int cy);
    apb(1'b1, `ATC_OFF_TRIG, tg);
    apb(1'b1, `ATC_OFF_DELAY, dl);
    @(posedge pclk);
    pwm_period_match_flag <= (f == 0);
    pwm_duty_match_flag <= (f > 0) ? 3'b001 << (f - 1) : 3'b000;
    cy = -1;
    for (int n = 0; n < 300 && cy < 0; n++) begin
      @(posedge pclk);
      if (sample_en === 1'b1) cy = n;
    end
    pwm_period_match_flag <= 1'b0;
    pwm_duty_match_flag <= 3'b000;
    repeat (40) @(posedge pclk);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {pwm_period_match_flag, pwm_duty_match_flag, conv_result_value} = '0;
    err_count = 0;
    n_checks = 0;
    void'($urandom(78518));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`ATC_OFF_INSEL, 32'h0, "insel reset");
    rdc(`ATC_OFF_TRIG, 32'h0, "trig reset");
    rdc(`ATC_OFF_DELAY, 32'h0, "delay reset");
    apb(1'b1, `ATC_OFF_INSEL, 32'hff);
    rdc(`ATC_OFF_INSEL, 32'he7, "insel bits");
    apb(1'b1, `ATC_OFF_TRIG, 32'hff);
    rdc(`ATC_OFF_TRIG, 32'hfb, "trig bits");
    apb(1'b1, `ATC_OFF_TRIG, 32'h0);
    apb(1'b1, 8'h30, 32'h55);
    chk("unmapped err", 32'h1, er);
    // reserved channel codes get the hand-picked slots 0 and 4
    for (int s = 0; s < 8; s++) begin
      ch = (s == 0) ? 4'hb : (s == 4) ? 4'hf : 4'($urandom);
      apb(1'b1, `ATC_OFF_CTRL0, {24'h0, 4'h2, ch});
      apb(1'b1, `ATC_OFF_INSEL, {24'h0, 3'(s), 5'h0});
      repeat (3) @(posedge pclk);
      isx = (s > 3) || (s == 0);
      chk("path", {isx && ch < 4'ha, s == 1, s == 2 || s == 3},
          {ext_path_en, amp_path_en, gnd_path_en});
      chk("chan", ch, external_channel_field);
    end
    for (int i = 0; i < 8; i++) begin
      al = 1'($urandom);
      {v, lo, hi} = 36'({$urandom, $urandom});
      m = 2'($urandom);
      en = 2'($urandom);
      div = (i == 4) ? 3'h7 : 3'($urandom);
      if (i < 4) begin
        m = 2'(i);
        v = i[0] ? lo : hi;
      end
      apb(1'b1, `ATC_OFF_CTRL0, {24'h0, 3'b001, al, 4'h0});
      apb(1'b1, `ATC_OFF_INSEL, {24'h0, 3'b001, 2'b00, div});
      apb(1'b1, `ATC_OFF_TRIG, {24'h0, 3'b000, m, 3'b000});
      b = fmt(lo, al);
      apb(1'b1, `ATC_OFF_LOW_HI, b[15:8]);
      apb(1'b1, `ATC_OFF_LOW_LO, b[7:0]);
      b = fmt(hi, al);
      apb(1'b1, `ATC_OFF_HIGH_HI, b[15:8]);
      apb(1'b1, `ATC_OFF_HIGH_LO, b[7:0]);
      apb(1'b1, `ATC_OFF_IRQ_EN, en);
      apb(1'b1, `ATC_OFF_IRQ_ST, 32'h3);
      conv_result_value <= v;
      conv(al);
      b = fmt(v, al);
      h = hit(v, lo, hi, m);
      rdc(`ATC_OFF_RES_HI, b[15:8], "result hi");
      rdc(`ATC_OFF_RES_LO, b[7:0], "result lo");
      rdc(`ATC_OFF_IRQ_ST, {h, 1'b1}, "irq flags");
      chk("irq out", {en[1] & h, en[0]}, {cmp_irq, conv_irq});
    end
    apb(1'b1, `ATC_OFF_CTRL0, 32'h0);
    rdc(`ATC_OFF_RES_HI, 32'h0, "off result hi");
    rdc(`ATC_OFF_RES_LO, 32'h0, "off result lo");
    b = fmt(lo, 1'b0);
    rdc(`ATC_OFF_LOW_HI, b[15:8], "bound kept");
    apb(1'b1, `ATC_OFF_IRQ_ST, 32'h3);
    repeat (3) @(posedge pclk);
    chk("irq cleared", 32'h0, {cmp_irq, conv_irq});
    chk("power off", 32'h0, converter_power_enable);
    apb(1'b1, `ATC_OFF_CTRL0, 32'h20);
    apb(1'b1, `ATC_OFF_INSEL, 32'h0);
    chk("power on", 32'h1, converter_power_enable);
    // delay is measured against the undelayed path, not absolute
    lat(8'h80, 8'h0, 0, base);
    for (int k = 0; k < 2; k++) begin
      d = k ? 8'(1 + $urandom % 60) : 8'h1;
      lat(8'hc0, d, 0, c);
      chk("delay", base + d, c);
    end
    for (int k = 0; k < 4; k++) begin
      lat({6'b101000, 2'(k)}, 8'h0, (k > 2) ? 3 : k + 1, c);
      chk("duty pick", base, c);
    end
    lat(8'ha0, 8'h0, 2, c);
    chk("other duty", -1, c);
    lat(8'h80, 8'h0, 1, c);
    chk("duty ignored", -1, c);
    lat(8'h00, 8'h0, 0, c);
    chk("pwm ignored", -1, c);
    tally_and_finish();
  end
endmodule
`default_nettype wire
